// ===== core/amr_consts.svh
`ifndef AMR_CONSTS_SVH
`define AMR_CONSTS_SVH

// register addresses
`define AMR_ADDR_W 6
`define AMR_ADDR_STATUS 6'h01
`define AMR_ADDR_MODE 6'h02
`define AMR_ADDR_CLOCK 6'h03
`define AMR_ADDR_GAIN 6'h04

// reset values
`define AMR_MODE_RST 16'h0510
`define AMR_CLOCK_RST 16'h030e
`define AMR_GAIN_RST 16'h0000

// mode field positions
`define AMR_MODE_REGCRC 13
`define AMR_MODE_RXCRC 12
`define AMR_MODE_CRCTYPE 11
`define AMR_MODE_RSTACK 10
`define AMR_MODE_WSZ_HI 9
`define AMR_MODE_WSZ_LO 8
`define AMR_MODE_TIMEOUT 4
`define AMR_MODE_SRC_HI 3
`define AMR_MODE_SRC_LO 2
`define AMR_MODE_FLOAT 1
`define AMR_MODE_SHAPE 0

// clock field positions
`define AMR_CLK_CH1 9
`define AMR_CLK_CH0 8
`define AMR_CLK_DIV_HI 7
`define AMR_CLK_DIV_LO 6
`define AMR_CLK_TURBO 5
`define AMR_CLK_OSR_HI 4
`define AMR_CLK_OSR_LO 2
`define AMR_CLK_PWR_HI 1
`define AMR_CLK_PWR_LO 0

// gain field positions
`define AMR_GAIN1_HI 6
`define AMR_GAIN1_LO 4
`define AMR_GAIN0_HI 2
`define AMR_GAIN0_LO 0

// status reset flag position
`define AMR_STAT_RESET 10

// writable masks, reserved bits held at zero
`define AMR_MODE_MASK 16'h3f1f
`define AMR_CLOCK_MASK 16'h03ff
`define AMR_GAIN_MASK 16'h0077

// ready pulse length, time and cycles at 10 MHz
`define AMR_CLK_NS 100
`define AMR_PULSE_NS 400
`define AMR_PULSE_CYC ((`AMR_PULSE_NS + `AMR_CLK_NS - 1) / `AMR_CLK_NS)

// turbo and base oversampling
`define AMR_TURBO_OSR 64
`define AMR_BASE_OSR 128

`endif

// ===== core/amr_pkg.sv
package amr_pkg;
  typedef enum logic [1:0] {
    AMR_WS_16, AMR_WS_24, AMR_WS_32_PAD, AMR_WS_32_SEXT
  } amr_word_size_t;
  typedef enum logic [1:0] {
    AMR_SRC_LAG, AMR_SRC_OR, AMR_SRC_LEAD, AMR_SRC_LEAD2
  } amr_src_t;
  typedef enum logic [1:0] {
    AMR_PWR_RSV0, AMR_PWR_LOW, AMR_PWR_HIRES, AMR_PWR_RSV3
  } amr_power_t;
endpackage

// ===== core/amr_ready_if.sv
`timescale 1ns/1ps
interface amr_ready_if;
  logic [1:0] chan_en;
  logic [1:0] chan_ready;
  logic [1:0] src;
  logic float_sel;
  logic shape_sel;
  logic pin_out;
  logic pin_oe;
  modport bank (output chan_en, chan_ready, src, float_sel, shape_sel, input pin_out, pin_oe);
  modport pin (input chan_en, chan_ready, src, float_sel, shape_sel, output pin_out, pin_oe);
endinterface

// ===== core/amr_ready_pin.sv
`timescale 1ns/1ps
`include "amr_consts.svh"
module amr_ready_pin #(
  parameter int PULSE_CYC = `AMR_PULSE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  amr_ready_if.pin rif
);
  logic [1:0] seen;
  logic avail;
  logic prev_avail;
  logic [7:0] pulse_cnt;
  logic lag_all;
  logic any_ch;

  ////////////////////////////////////////////////////////////////////
  // lagging: all enabled channels seen; leading / or: any channel
  assign lag_all = ((seen | rif.chan_ready) & rif.chan_en) == rif.chan_en
                   && rif.chan_en != 2'h0;
  assign any_ch = |(rif.chan_ready & rif.chan_en);

  // collect per-channel arrivals for lagging mode
  always_ff @(posedge clk) begin
    if (reset || lag_all) begin
      seen <= 2'h0;
    end else begin
      seen <= seen | (rif.chan_ready & rif.chan_en);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      avail <= 1'b0;
    end else if (rif.src == 2'h0) begin
      avail <= lag_all ? 1'b1 : (avail & ~any_ch);
    end else begin
      avail <= any_ch ? 1'b1 : avail;
    end
  end

  // edge tracking for pulse start
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_avail <= 1'b0;
    end else begin
      prev_avail <= avail;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_cnt <= 8'h00;
    end else if (avail && !prev_avail) begin
      pulse_cnt <= 8'(PULSE_CYC);
    end else if (pulse_cnt != 8'h00) begin
      pulse_cnt <= pulse_cnt - 8'h01;
    end
  end

  // idle high or released; low level or pulse
  always_comb begin
    if (rif.shape_sel ? (pulse_cnt != 8'h00) : avail) begin
      rif.pin_out = 1'b0;
      rif.pin_oe = 1'b1;
    end else begin
      rif.pin_out = 1'b1;
      rif.pin_oe = ~rif.float_sel;
    end
  end
endmodule

// ===== core/amr_regs.sv
`timescale 1ns/1ps
`include "amr_consts.svh"
// Notes on behaviour
// - register map check runs only with its mode enable set; cleared at reset
// - incoming frame check runs only with input check enable set
// - one polynomial bit selects crc flavour everywhere: 0 ccitt, 1 ansi
// - reset ack bit resets to one; writing zero clears status reset flag
// - word size field picks 16, 24, 32 padded or 32 sign-extended
// - serial timeout active only while timeout enable set; set after reset
// - ready pin follows lagging, or of all, or leading enabled channel
// - with no data, ready pin high or floating per float bit
// - with data, ready pin low level or fixed low pulse per shape
// - channels convert only while enabled; both enabled after reset
// - divider codes give divide by 2, 4, 8, 12; default 2
// - turbo forces oversampling 64 and ignores ratio field
// - ratio is 128 shifted by code; reset code gives 1024
// - power mode low or high resolution; host avoids reserved codes
// - channel 1 gain bits 6:4 give 1 to 128
// - channel 0 gain bits 2:0 same encoding; unity after reset
// - reset loads mode 0510h, clock 030eh, gain 0000h
// - reset-occurred flag set by any reset until host acknowledges
module amr_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`AMR_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_map_crc_en,
  output logic rx_crc_en,
  output logic crc_poly_ansi,
  output logic reset_occurred,
  output logic [1:0] word_size_sel,
  output logic [5:0] frame_bits,
  output logic timeout_en,
  input wire logic timeout_event,
  output logic timeout_fire,
  input wire logic [1:0] chan_sample_ready,
  output logic sample_ready_pin_out,
  output logic sample_ready_pin_oe,
  output logic chan0_convert_en,
  output logic chan1_convert_en,
  output logic [3:0] clock_divisor,
  output logic [14:0] oversample_ratio,
  output logic [2:0] oversample_ratio_sel,
  output logic turbo_en,
  output logic [1:0] power_profile_sel,
  output logic power_profile_bad,
  output logic [2:0] chan0_amp_gain,
  output logic [2:0] chan1_amp_gain,
  output logic [7:0] chan0_gain_value,
  output logic [7:0] chan1_gain_value
);
  logic [15:0] mode_control;
  logic [15:0] clock_config;
  logic [15:0] gain_select;
  logic [15:0] next_rdata;
  amr_pkg::amr_word_size_t ws;
  amr_pkg::amr_power_t pw;

  amr_ready_if rif ();

  ////////////////////////////////////////////////////////////////////
  // mode register
  // reset load; host write; reserved kept zero
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_control <= `AMR_MODE_RST;
    end else if (reg_wr && reg_addr == `AMR_ADDR_MODE) begin
      mode_control <= reg_wdata & `AMR_MODE_MASK;
    end
  end

  // clock register
  // reset load; host write
  always_ff @(posedge clk) begin
    if (reset) begin
      clock_config <= `AMR_CLOCK_RST;
    end else if (reg_wr && reg_addr == `AMR_ADDR_CLOCK) begin
      clock_config <= reg_wdata & `AMR_CLOCK_MASK;
    end
  end

  // gain register
  // reset load; host write
  always_ff @(posedge clk) begin
    if (reset) begin
      gain_select <= `AMR_GAIN_RST;
    end else if (reg_wr && reg_addr == `AMR_ADDR_GAIN) begin
      gain_select <= reg_wdata & `AMR_GAIN_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flag set by reset, held until acknowledged
  // zero written to ack bit clears flag
  always_ff @(posedge clk) begin
    if (reset) begin
      reset_occurred <= 1'b1;
    end else if (reg_wr && reg_addr == `AMR_ADDR_MODE
                 && !reg_wdata[`AMR_MODE_RSTACK]) begin
      reset_occurred <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read decode; unmapped addresses read zero
  // readback of all fields
  always_comb begin
    if (reg_addr == `AMR_ADDR_MODE) begin
      next_rdata = mode_control;
    end else if (reg_addr == `AMR_ADDR_CLOCK) begin
      next_rdata = clock_config;
    end else if (reg_addr == `AMR_ADDR_GAIN) begin
      next_rdata = gain_select;
    end else if (reg_addr == `AMR_ADDR_STATUS) begin
      next_rdata = {5'h00, reset_occurred, mode_control[9:8], 8'h00};
    end else begin
      next_rdata = 16'h0000;
    end
  end

  // read data register
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // crc controls
  // map check enable
  assign reg_map_crc_en = mode_control[`AMR_MODE_REGCRC];
  assign rx_crc_en = mode_control[`AMR_MODE_RXCRC];
  assign crc_poly_ansi = mode_control[`AMR_MODE_CRCTYPE];

  assign word_size_sel = mode_control[`AMR_MODE_WSZ_HI:`AMR_MODE_WSZ_LO];
  assign ws = amr_pkg::amr_word_size_t'(word_size_sel);
  always_comb begin
    case (ws)
      amr_pkg::AMR_WS_16: frame_bits = 6'h10;
      amr_pkg::AMR_WS_24: frame_bits = 6'h18;
      default: frame_bits = 6'h20;
    endcase
  end

  assign timeout_en = mode_control[`AMR_MODE_TIMEOUT];
  assign timeout_fire = timeout_en & timeout_event;

  ////////////////////////////////////////////////////////////////////
  // ready pin driver
  assign rif.chan_en = {chan1_convert_en, chan0_convert_en};
  assign rif.chan_ready = chan_sample_ready;
  assign rif.src = mode_control[`AMR_MODE_SRC_HI:`AMR_MODE_SRC_LO];
  assign rif.float_sel = mode_control[`AMR_MODE_FLOAT];
  assign rif.shape_sel = mode_control[`AMR_MODE_SHAPE];
  assign sample_ready_pin_out = rif.pin_out;
  assign sample_ready_pin_oe = rif.pin_oe;

  amr_ready_pin u_ready (
    .clk(clk),
    .reset(reset),
    .rif(rif.pin)
  );

  ////////////////////////////////////////////////////////////////////
  // channel enables
  assign chan0_convert_en = clock_config[`AMR_CLK_CH0];
  assign chan1_convert_en = clock_config[`AMR_CLK_CH1];

  always_comb begin
    case (clock_config[`AMR_CLK_DIV_HI:`AMR_CLK_DIV_LO])
      2'h0: clock_divisor = 4'h2;
      2'h1: clock_divisor = 4'h4;
      2'h2: clock_divisor = 4'h8;
      default: clock_divisor = 4'hc;
    endcase
  end

  // turbo override; 128 shifted by code
  assign turbo_en = clock_config[`AMR_CLK_TURBO];
  assign oversample_ratio_sel = clock_config[`AMR_CLK_OSR_HI:`AMR_CLK_OSR_LO];
  always_comb begin
    if (turbo_en) begin
      oversample_ratio = 15'(`AMR_TURBO_OSR);
    end else begin
      oversample_ratio = 15'(`AMR_BASE_OSR) << oversample_ratio_sel;
    end
  end

  // power mode and reserved code flag
  assign power_profile_sel = clock_config[`AMR_CLK_PWR_HI:`AMR_CLK_PWR_LO];
  assign pw = amr_pkg::amr_power_t'(power_profile_sel);
  assign power_profile_bad = (pw == amr_pkg::AMR_PWR_RSV0) || (pw == amr_pkg::AMR_PWR_RSV3);

  ////////////////////////////////////////////////////////////////////
  // channel 1 and channel 0 gain
  assign chan1_amp_gain = gain_select[`AMR_GAIN1_HI:`AMR_GAIN1_LO];
  assign chan1_gain_value = 8'h01 << chan1_amp_gain;
  assign chan0_amp_gain = gain_select[`AMR_GAIN0_HI:`AMR_GAIN0_LO];
  assign chan0_gain_value = 8'h01 << chan0_amp_gain;
endmodule

// ===== testbench/amr_regs_assertions.sv
`timescale 1ns/1ps
module amr_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rvalid,
  input wire logic reg_map_crc_en,
  input wire logic rx_crc_en,
  input wire logic crc_poly_ansi,
  input wire logic reset_occurred,
  input wire logic [1:0] word_size_sel,
  input wire logic [5:0] frame_bits,
  input wire logic timeout_en,
  input wire logic timeout_event,
  input wire logic timeout_fire,
  input wire logic sample_ready_pin_out,
  input wire logic sample_ready_pin_oe,
  input wire logic chan0_convert_en,
  input wire logic chan1_convert_en,
  input wire logic [14:0] oversample_ratio,
  input wire logic [2:0] oversample_ratio_sel,
  input wire logic turbo_en,
  input wire logic [1:0] power_profile_sel,
  input wire logic [2:0] chan0_amp_gain,
  input wire logic [2:0] chan1_amp_gain,
  input wire logic [7:0] chan0_gain_value,
  input wire logic [7:0] chan1_gain_value
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // write to the mode register
  sequence mode_wr_s;
    reg_wr && reg_addr == 6'h02;
  endsequence
  ////////////////////////////////////////////////////////////////
  read_valid_a: assert property (reg_rd |=> reg_rvalid) else $error("no read valid");
  stray_valid_a: assert property (!reg_rd |=> !reg_rvalid) else $error("stray valid");
  mode_fields_a: assert property (mode_wr_s |=> {reg_map_crc_en, rx_crc_en, crc_poly_ansi,
    word_size_sel, timeout_en} == {$past(reg_wdata[13:11]), $past(reg_wdata[9:8]),
    $past(reg_wdata[4])}) else $error("mode fields wrong");
  ack_clear_a: assert property (mode_wr_s ##0 !reg_wdata[10] |=> !reset_occurred)
    else $error("flag not cleared");
  reset_defaults_a: assert property ($fell(reset) |-> reset_occurred && timeout_en
    && !reg_map_crc_en && !rx_crc_en && word_size_sel == 2'b01 && chan0_convert_en
    && chan1_convert_en && oversample_ratio_sel == 3'd3 && power_profile_sel == 2'b10
    && sample_ready_pin_out && sample_ready_pin_oe) else $error("bad reset state");
  ratio_pick_a: assert property (oversample_ratio == (turbo_en ? 15'd64 :
    15'd128 << oversample_ratio_sel)) else $error("ratio wrong");
  gain_map_a: assert property (chan0_gain_value == 8'h01 << chan0_amp_gain
    && chan1_gain_value == 8'h01 << chan1_amp_gain) else $error("gain wrong");
  frame_len_a: assert property (frame_bits == (word_size_sel == 2'b00 ? 6'd16 :
    word_size_sel == 2'b01 ? 6'd24 : 6'd32)) else $error("frame wrong");
  timeout_gate_a: assert property (timeout_fire == (timeout_event && timeout_en))
    else $error("timeout gate wrong");
endmodule
bind amr_regs amr_chk chk_u (.clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rvalid, .reg_map_crc_en, .rx_crc_en, .crc_poly_ansi, .reset_occurred,
  .word_size_sel, .frame_bits, .timeout_en, .timeout_event, .timeout_fire,
  .sample_ready_pin_out, .sample_ready_pin_oe, .chan0_convert_en, .chan1_convert_en,
  .oversample_ratio, .oversample_ratio_sel, .turbo_en, .power_profile_sel,
  .chan0_amp_gain, .chan1_amp_gain, .chan0_gain_value, .chan1_gain_value);

// ===== testbench/amr_host.sv
`timescale 1ns/1ps
module amr_host (
  input wire logic clk,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [5:0] reg_addr = 6'h00,
  output logic [15:0] reg_wdata = 16'h0000
);
  // one write, held through the taking edge
  task automatic write(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d & (a == 6'h02 ? 16'h3f1f : a == 6'h03 ? 16'h03ff : 16'h0077);
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // released data does not linger
    @(negedge clk);
  endtask
  // one read, answer taken in the valid cycle
  task automatic read(input logic [5:0] a, output logic [15:0] d, output logic v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin \
  samples_checked++; \
  if ((a) !== (e)) begin \
    $display("wrong value %s exp %0h got %0h", n, e, a); \
    err_count++; \
  end \
end
module tb;
  logic clk = 1'b0, reset = 1'b1, rvalid, v, pin_out, pin_oe, crc_a, crc_b, crc_c, ack;
  logic wr, rd, tev = 1'b0, fire, ch0, ch1, pbad;
  logic [1:0] csr = 2'b00;
  logic [5:0] addr, fbits;
  logic [15:0] wdata, rdata, d;
  logic [3:0] cdiv;
  logic [14:0] ratio;
  logic [7:0] g0, g1;
  logic [3:0] dtab [4] = '{4'd2, 4'd4, 4'd8, 4'd12};
  int err_count = 0, samples_checked = 0, cyc = 0, n;
  amr_regs dut_u (.clk(clk), .reset(reset), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .reg_map_crc_en(crc_a),
    .rx_crc_en(crc_b), .crc_poly_ansi(crc_c), .reset_occurred(ack), .word_size_sel(),
    .frame_bits(fbits), .timeout_en(), .timeout_event(tev), .timeout_fire(fire),
    .chan_sample_ready(csr), .sample_ready_pin_out(pin_out), .sample_ready_pin_oe(pin_oe),
    .chan0_convert_en(ch0), .chan1_convert_en(ch1), .clock_divisor(cdiv),
    .oversample_ratio(ratio), .oversample_ratio_sel(), .turbo_en(), .power_profile_sel(),
    .power_profile_bad(pbad), .chan0_amp_gain(), .chan1_amp_gain(), .chan0_gain_value(g0),
    .chan1_gain_value(g1));
  amr_host host_u (.clk(clk), .reg_rdata(rdata), .reg_rvalid(rvalid), .reg_wr(wr),
    .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata));
  always #50 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////
  task rchk(input logic [5:0] a, input logic [15:0] e);
    host_u.read(a, d, v);
    `CHK("rvalid", 1'b1, v)
    `CHK("rdata", e, d)
  endtask
  task rst;
    @(posedge clk) reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
  endtask
  // one-cycle sample ready on the channels in m
  task pulse(input logic [1:0] m);
    @(posedge clk) csr <= m;
    @(posedge clk) csr <= 2'b00;
    @(negedge clk);
  endtask
  task results;
    $display("mismatches %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rchk(6'h02, 16'h0510);
    rchk(6'h03, 16'h030e);
    rchk(6'h04, 16'h0000);
    rchk(6'h01, 16'h0500);
    rchk(6'h05, 16'h0000);
    `CHK("pin", 2'b11, {pin_out, pin_oe})
    @(posedge clk) tev <= 1'b1;
    @(negedge clk) `CHK("fire", 1'b1, fire)
    host_u.write(6'h02, 16'h3a0d);
    `CHK("fire", 1'b0, fire)
    `CHK("crc", 3'b111, {crc_a, crc_b, crc_c})
    `CHK("flag", 1'b0, ack)
    rchk(6'h02, 16'h3a0d);
    @(posedge clk) tev <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      host_u.write(6'h02, {6'h00, i[1:0], 8'h00});
      `CHK("frame", i == 0 ? 6'd16 : i == 1 ? 6'd24 : 6'd32, fbits)
    end
    // power code kept legal on every write
    for (int i = 0; i < 8; i++) begin
      host_u.write(6'h03, {6'h00, 2'b11, i[1:0], 1'b0, i[2:0], 2'b01});
      `CHK("div", dtab[i[1:0]], cdiv)
      `CHK("ratio", 15'd128 << i, ratio)
      `CHK("pwrbad", 1'b0, pbad)
    end
    host_u.write(6'h03, 16'h003e);
    `CHK("turbo", 15'd64, ratio)
    `CHK("pwrbad", 1'b0, pbad)
    `CHK("chen", 2'b00, {ch1, ch0})
    for (int i = 0; i < 8; i++) begin
      host_u.write(6'h04, {9'h000, i[2:0], 1'b0, ~i[2:0]});
      `CHK("gain", {8'h01 << i, 8'h01 << (7 - i)}, {g1, g0})
    end
    rst();
    rchk(6'h03, 16'h030e);
    host_u.write(6'h02, 16'h0514);
    pulse(2'b01);
    `CHK("low", 2'b01, {pin_out, pin_oe})
    rst();
    host_u.write(6'h02, 16'h0512);
    `CHK("float", 1'b0, pin_oe)
    host_u.write(6'h02, 16'h0515);
    pulse(2'b01);
    n = 0;
    repeat (10) begin
      if (pin_out === 1'b0) n++;
      @(negedge clk);
    end
    `CHK("pulse", 4, n)
    // lagging source waits for both enabled channels
    rst();
    pulse(2'b01);
    `CHK("lag", 2'b11, {pin_out, pin_oe})
    pulse(2'b10);
    `CHK("lag", 2'b01, {pin_out, pin_oe})
    results();
  end
endmodule
